//--- core/apf_pkg.sv
// What this block does
// RULE1: wrap field 01 modulo 2, 10/11 modulo 4
// RULE2: control bits 5 to 2 read zero
// RULE3: step up if direction 0, down if 1
// RULE4: zeroing bit clears pointer, then self-clears
// RULE5: load instruction with zeroing bit skips stepping
// RULE6: status flags reset to 80h always
// RULE7: flags readable; only five bits software-writable
// RULE8: compare sets equal flag on match only
// RULE9: carry flag follows last carry or borrow; here AND/OR/XOR clear it and compare leaves it unchanged
// RULE10: software writing one sets equal or carry
// RULE11: add overflow when one of carries 14/15
// RULE12: subtract overflow when one borrow into 14/15
// RULE13: overflow flag readable and writable by software
// RULE14: pointer low bits pick accumulator, upper zero
// RULE15: wrap field 00 default, no stepping
// RULE16: zero flag is NOR of active accumulator
// RULE17: stepping wraps cyclically within selected modulus
package apf_pkg;

    // ****************************************
    // register indices, byte address is four times
    // ****************************************
    localparam logic [3:0] PTR_IDX = 4'h0;  // active_accumulator_pointer
    localparam logic [3:0] CTL_IDX = 4'h1;  // pointer_stepping_control
    localparam logic [3:0] FLG_IDX = 4'h4;  // processor_flags
    localparam logic [3:0] ACC_IDX = 4'h8;  // active accumulator view

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [7:0] PTR_RST     = 8'h00;
    localparam logic [7:0] CTL_RST     = 8'h00;
    localparam logic [7:0] FLG_RST     = 8'h80;
    localparam logic [7:0] CTL_RD_MASK = 8'hC3;  // bits 5:2 never read back
    localparam logic [4:0] SWF_RST     = 5'h00;  // stored soft-writable flags

    // ****************************************
    // field positions
    // ****************************************
    localparam int FLG_E   = 0;  // equal
    localparam int FLG_C   = 1;  // carry
    localparam int FLG_SW  = 2;  // signed_wrap_flag
    localparam int FLG_G0  = 3;  // spare_flag_zero
    localparam int FLG_G1  = 4;  // spare_flag_one
    localparam int FLG_S   = 6;  // sign
    localparam int FLG_Z   = 7;  // zero
    localparam int CTL_DIR = 6;  // step_direction_select
    localparam int CTL_CLR = 7;  // pointer_zeroing_bit

    // wrap_modulus_select codes
    localparam logic [1:0] MOD_NONE = 2'b00;
    localparam logic [1:0] MOD_TWO  = 2'b01;

    // operations issued by instruction execution
    typedef enum logic [2:0] {
        OP_LOAD  = 3'h0,  // plain load of active accumulator
        OP_ADD   = 3'h1,
        OP_SUB   = 3'h2,
        OP_CMP   = 3'h3,
        OP_AND   = 3'h4,
        OP_OR    = 3'h5,
        OP_XOR   = 3'h6,
        OP_MVAPC = 3'h7   // pointer_control_load_instruction
    } apf_op_t;

    // arithmetic or logical ops that write the accumulator
    function automatic logic apf_is_alu(input logic [2:0] k);
        return (k == OP_ADD) || (k == OP_SUB) || (k == OP_AND)
            || (k == OP_OR) || (k == OP_XOR);
    endfunction

endpackage

//--- core/apf_alu.sv
module apf_alu (
    input  wire logic [15:0] opA,
    input  wire logic [15:0] opB,
    input  wire logic        isSub,
    output logic      [15:0] result,
    output logic             carry,
    output logic             ovf
);
    import apf_pkg::*;

    // ****************************************
    // add or subtract with carry tap at bit 14
    // ****************************************
    logic [15:0] bIn;   // operand b, inverted for subtraction
    logic [15:0] low;   // sum of bits 14:0, bit 15 is carry out of 14
    logic [16:0] full;  // full sum, bit 16 is carry out of 15

    always_comb begin
        bIn    = isSub ? ~opB : opB;
        low    = {1'b0, opA[14:0]} + {1'b0, bIn[14:0]} + {15'h0000, isSub};
        full   = {1'b0, opA} + {1'b0, bIn} + {16'h0000, isSub};
        result = full[15:0];
        // borrow is the inverted carry of the two's complement sum
        carry  = isSub ? ~full[16] : full[16]; // RULE9
        // borrows into 14/15 map onto the same carry pair
        ovf    = low[15] ^ full[16]; // RULE11 RULE12
    end

endmodule

//--- core/apf_step.sv
module apf_step (
    input  wire logic [1:0] ptr,
    input  wire logic [1:0] wrapSel,
    input  wire logic       down,
    output logic      [1:0] nxtPtr
);
    import apf_pkg::*;

    // ****************************************
    // modulo stepping of the pointer
    // ****************************************
    always_comb begin
        unique case (wrapSel)
            MOD_NONE: begin
                nxtPtr = ptr; // RULE15
            end
            MOD_TWO: begin
                // only bit 0 toggles, up or down alike
                nxtPtr = {ptr[1], ~ptr[0]}; // RULE1 RULE17
            end
            default: begin
                // 10 and reserved 11 both count modulo 4
                nxtPtr = down ? ptr - 2'b01 : ptr + 2'b01; // RULE1 RULE3 RULE17
            end
        endcase
    end

endmodule

//--- core/apf_core.sv
module apf_core (
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire logic [5:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  opValid,
    input  wire apf_pkg::apf_op_t      opKind,
    input  wire logic [15:0]           opOperand,
    output logic      [1:0]            activePointer,
    output logic      [15:0]           activeAcc,
    output logic      [7:0]            processorFlags
);
    import apf_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [15:0] acc_ff [4];     // four accumulators
    logic [1:0]  ptr_ff;         // active_accumulator_pointer
    logic [1:0]  wrap_ff;        // wrap_modulus_select
    logic        dir_ff;         // step_direction_select
    logic        clr_ff;         // pointer_zeroing_bit
    logic [4:0]  swf_ff;         // ov, e, c, spare flags
    logic        wait_ff;        // waitrequest flop
    logic [31:0] rdata_ff;       // read data flop
    logic [15:0] actAcc_ff;      // copy of active accumulator
    logic [7:0]  flags_ff;       // assembled processor_flags

    // ****************************************
    // combinational next values
    // ****************************************
    logic [15:0] nxtAcc [4];     // accumulators after this cycle
    logic [1:0]  nxtPtr;         // pointer after this cycle
    logic [1:0]  stepPtr;        // pointer advanced by one step
    logic [15:0] aluRes;         // adder result
    logic        aluCarry;       // carry or borrow
    logic        aluOvf;         // signed overflow
    logic        busAcc;         // request accepted this edge
    logic        wrPtr;          // bus write to pointer
    logic        wrCtl;          // bus write to control
    logic        wrFlg;          // bus write to flags
    logic        ldCtl;          // pointer_control_load_instruction
    logic        doStep;         // pointer steps this edge
    logic [7:0]  ctlData;        // value loaded into control
    logic        eqHit;          // compare match
    logic [15:0] curAcc;         // active accumulator now

    assign curAcc = acc_ff[ptr_ff];
    assign eqHit  = (curAcc == opOperand);

    // ****************************************
    // arithmetic and stepping helpers
    // ****************************************
    apf_alu uAlu (
        .opA    (curAcc),
        .opB    (opOperand),
        .isSub  ((opKind == OP_SUB) || (opKind == OP_CMP)),
        .result (aluRes),
        .carry  (aluCarry),
        .ovf    (aluOvf)
    );

    apf_step uStep (
        .ptr     (ptr_ff),
        .wrapSel (wrap_ff),
        .down    (dir_ff),
        .nxtPtr  (stepPtr)
    );

    // ****************************************
    // bus decode
    // ****************************************
    // a request is taken only on the edge where waitrequest is low
    always_comb begin
        busAcc = !wait_ff && (avs_read || avs_write);
        wrPtr  = busAcc && avs_write && avs_byteenable[0] && (avs_address[5:2] == PTR_IDX);
        wrCtl  = busAcc && avs_write && avs_byteenable[0] && (avs_address[5:2] == CTL_IDX);
        wrFlg  = busAcc && avs_write && avs_byteenable[0] && (avs_address[5:2] == FLG_IDX);
        ldCtl  = opValid && (opKind == OP_MVAPC);
        // instruction load wins over a bus write in the same cycle
        ctlData = ldCtl ? curAcc[7:0] : avs_writedata[7:0];
    end

    // ****************************************
    // pointer and accumulator next values
    // ****************************************
    always_comb begin
        nxtAcc = acc_ff;
        // a load that sets the zeroing bit does nothing else
        doStep = opValid && (apf_is_alu(opKind)
                 || (ldCtl && !curAcc[CTL_CLR])); // RULE3 RULE5
        if (opValid) begin
            unique case (opKind)
                OP_LOAD: nxtAcc[ptr_ff] = opOperand;
                OP_ADD:  nxtAcc[ptr_ff] = aluRes;
                OP_SUB:  nxtAcc[ptr_ff] = aluRes;
                OP_AND:  nxtAcc[ptr_ff] = curAcc & opOperand;
                OP_OR:   nxtAcc[ptr_ff] = curAcc | opOperand;
                OP_XOR:  nxtAcc[ptr_ff] = curAcc ^ opOperand;
                OP_CMP:  nxtAcc[ptr_ff] = curAcc;
                OP_MVAPC: nxtAcc[ptr_ff] = curAcc;
            endcase
        end
        // pending clear beats bus write, which beats stepping
        if (clr_ff) begin
            nxtPtr = 2'b00; // RULE4
        end else if (wrPtr) begin
            nxtPtr = avs_writedata[1:0]; // RULE14
        end else if (doStep) begin
            nxtPtr = stepPtr; // RULE3 RULE17
        end else begin
            nxtPtr = ptr_ff;
        end
    end

    // ****************************************
    // accumulator storage
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                acc_ff[i] <= 16'h0000;
            end
        end else begin
            acc_ff <= nxtAcc;
        end
    end

    // ****************************************
    // pointer register
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ptr_ff <= PTR_RST[1:0];
        end else begin
            ptr_ff <= nxtPtr; // RULE14
        end
    end

    // ****************************************
    // pointer stepping control
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrap_ff <= CTL_RST[1:0]; // RULE15
            dir_ff  <= CTL_RST[CTL_DIR];
            clr_ff  <= CTL_RST[CTL_CLR];
        end else if (wrCtl || ldCtl) begin
            wrap_ff <= ctlData[1:0];
            dir_ff  <= ctlData[CTL_DIR];
            clr_ff  <= ctlData[CTL_CLR]; // RULE4
        end else if (clr_ff) begin
            // self-clears on the edge that zeroes the pointer
            clr_ff <= 1'b0; // RULE4
        end
    end

    // ****************************************
    // software-writable flags
    // ****************************************
    // hardware results override a bus write in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            swf_ff <= SWF_RST; // RULE6
        end else begin
            if (wrFlg) begin
                swf_ff <= avs_writedata[4:0]; // RULE7 RULE10 RULE13
            end
            if (opValid && (opKind == OP_CMP)) begin
                swf_ff[FLG_E] <= eqHit; // RULE8
            end
            if (opValid && apf_is_alu(opKind)) begin
                swf_ff[FLG_C] <= aluCarry && ((opKind == OP_ADD) || (opKind == OP_SUB)); // RULE9
            end
            if (opValid && ((opKind == OP_ADD) || (opKind == OP_SUB))) begin
                swf_ff[FLG_SW] <= aluOvf; // RULE11 RULE12
            end
        end
    end

    // ****************************************
    // output copies of active state
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            actAcc_ff <= 16'h0000;
        end else begin
            actAcc_ff <= nxtAcc[nxtPtr];
        end
    end

    // zero and sign track the accumulator that will be active next
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags_ff <= FLG_RST; // RULE6
        end else begin
            flags_ff[FLG_Z] <= ~|nxtAcc[nxtPtr]; // RULE16
            flags_ff[FLG_S] <= nxtAcc[nxtPtr][15];
            flags_ff[5]     <= 1'b0;
            flags_ff[4:0]   <= swf_ff; // RULE7
        end
    end

    // ****************************************
    // avalon slave: one wait state per access
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_ff <= 1'b1;
        end else if (busAcc) begin
            wait_ff <= 1'b1;
        end else if (avs_read || avs_write) begin
            wait_ff <= 1'b0;
        end
    end

    // read data is loaded as waitrequest drops, so it stands at the taking edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && wait_ff) begin
            unique case (avs_address[5:2])
                PTR_IDX: rdata_ff <= {30'h0000_0000, ptr_ff}; // RULE14
                CTL_IDX: rdata_ff <= {24'h00_0000, {clr_ff, dir_ff, 4'h0, wrap_ff}
                                      & CTL_RD_MASK}; // RULE2
                FLG_IDX: rdata_ff <= {24'h00_0000, flags_ff}; // RULE7
                ACC_IDX: rdata_ff <= {16'h0000, curAcc};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign activePointer   = ptr_ff;
    assign activeAcc       = actAcc_ff;
    assign processorFlags  = flags_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    wrap_two_a: assert property ( // RULE1
        (doStep && !clr_ff && !wrPtr && wrap_ff == MOD_TWO)
        |=> (ptr_ff[1] == $past(ptr_ff[1])) && (ptr_ff[0] != $past(ptr_ff[0])))
        else $error("modulo 2 step changed wrong bit");

    rsvd_read_a: assert property ( // RULE2
        (avs_read && wait_ff && avs_address[5:2] == CTL_IDX)
        |=> (avs_readdata[5:2] == 4'h0) && !avs_waitrequest)
        else $error("control reserved bits read nonzero");

    step_down_a: assert property ( // RULE3
        (doStep && !clr_ff && !wrPtr && wrap_ff[1] && dir_ff)
        |=> ptr_ff == $past(ptr_ff) - 2'b01)
        else $error("pointer did not decrement");

    zero_clear_a: assert property ( // RULE4
        (clr_ff && !wrCtl && !ldCtl) |=> (ptr_ff == 2'b00) && !clr_ff)
        else $error("zeroing bit did not clear pointer");

    load_nostep_a: assert property ( // RULE5
        (ldCtl && curAcc[CTL_CLR] && !clr_ff && !wrPtr)
        |=> (ptr_ff == $past(ptr_ff)) ##1 (ptr_ff == 2'b00))
        else $error("load with zeroing bit stepped pointer");

    flag_bit5_a: assert property ( // RULE7
        processorFlags[5] == 1'b0)
        else $error("reserved flag bit set");

    cmp_equal_a: assert property ( // RULE8
        (opValid && opKind == OP_CMP) |=> ##1 processorFlags[FLG_E] == $past(eqHit, 2))
        else $error("equal flag wrong after compare");

    add_carry_a: assert property ( // RULE9 RULE11
        (opValid && opKind == OP_ADD)
        |=> ##1 processorFlags[FLG_SW] == $past(aluOvf, 2)
            && processorFlags[FLG_C] == $past(aluCarry, 2))
        else $error("carry or overflow wrong after add");

    sw_set_a: assert property ( // RULE10 RULE13
        (wrFlg && !opValid) |=> ##1 processorFlags[4:0] == $past(avs_writedata[4:0], 2))
        else $error("software flag write lost");

    zero_flag_a: assert property ( // RULE16
        (processorFlags[FLG_Z] == ~|curAcc) && (activeAcc == curAcc))
        else $error("zero flag disagrees with accumulator");

    no_step_a: assert property ( // RULE15
        (wrap_ff == MOD_NONE && !clr_ff && !wrPtr) |=> ptr_ff == $past(ptr_ff))
        else $error("pointer stepped with stepping off");

    wrap4_c: cover property (doStep && wrap_ff[1] && ptr_ff == 2'b11 && !dir_ff);
    clear_c: cover property (clr_ff ##1 ptr_ff == 2'b00);
    ovf_c:   cover property (opValid && opKind == OP_SUB && aluOvf);
    bus_c:   cover property (avs_write && wait_ff ##1 busAcc);

endmodule

//--- tb/test_apf_core.sv
module test_apf_core;
    timeunit 1ns;
    timeprecision 1ps;
    import apf_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic              clk_sys;          // 20 MHz system clock
    logic              arst_n;           // async reset, active low
    logic [5:0]        avs_address;      // byte address
    logic              avs_read;         // read request
    logic              avs_write;        // write request
    logic [31:0]       avs_writedata;    // write data, lane 0 used
    logic [3:0]        avs_byteenable;   // lane enables
    logic [31:0]       avs_readdata;     // read data
    logic              avs_waitrequest;  // slave stall
    logic              opValid;          // operation strobe
    apf_op_t           opKind;           // operation code
    logic [15:0]       opOperand;        // operation operand
    logic [1:0]        activePointer;    // pointer copy
    logic [15:0]       activeAcc;        // accumulator copy
    logic [7:0]        processorFlags;   // flags copy
    int                errors;           // mismatches seen
    int                num_checks;       // comparisons made
    logic [7:0]        rdByte;           // scratch read value
    logic [1:0]        expPtr;           // expected pointer

    // byte addresses of the register map
    localparam logic [5:0] A_PTR = 6'h00;
    localparam logic [5:0] A_CTL = 6'h04;
    localparam logic [5:0] A_FLG = 6'h10;
    localparam logic [5:0] A_BAD = 6'h3C;  // nothing lives here

    apf_core u_apf_core (
        .clk_sys         (clk_sys),
        .arst_n          (arst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .opValid         (opValid),
        .opKind          (opKind),
        .opOperand       (opOperand),
        .activePointer   (activePointer),
        .activeAcc       (activeAcc),
        .processorFlags  (processorFlags)
    );

    // free-running clock, 50 ns period
    always #25 clk_sys = ~clk_sys;

    // ****************************************
    // helpers
    // ****************************************
    // verdict and end of run, the one exit point
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // compare one byte, report at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one bus access; request held until waitrequest seen low at an edge
    task automatic busXfer(input logic wr, input logic [5:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address   <= addr;
        avs_writedata <= {24'h00_0000, data};
        avs_write     <= wr;
        avs_read      <= ~wr;
        // request stands until waitrequest is sampled low at a rising edge
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            $display("unexpected at %0t: bus access timed out", $time);
            close_out();
        end
        rdByte = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        busXfer(1'b1, addr, data);
    endtask

    task automatic rdChk(input logic [5:0] addr, input logic [7:0] exp, input string what);
        busXfer(1'b0, addr, 8'h00);
        chk(rdByte, exp, what);
    endtask

    // one operation pulse, then let results settle into the port copies
    task automatic doOp(input apf_op_t kind, input logic [15:0] val);
        @(posedge clk_sys);
        opValid   <= 1'b1;
        opKind    <= kind;
        opOperand <= val;
        @(posedge clk_sys);
        opValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    // pointer after one step, worked out from the wrap rules
    function automatic logic [1:0] stepOf(input logic [1:0] p, input logic [1:0] m,
                                          input logic d);
        if (m == 2'b00) return p;
        if (m == 2'b01) return {p[1], ~p[0]};
        return d ? p - 2'd1 : p + 2'd1;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        apf_op_t ops[4];
        logic [15:0] va[6];
        apf_op_t     ko[6];
        logic [15:0] vb[6];
        logic [1:0]  ovc[6];
        ops = '{OP_ADD, OP_SUB, OP_AND, OP_XOR};
        va  = '{16'h7FFF, 16'hFFFF, 16'h8000, 16'h8000, 16'h0000, 16'h00F0};
        ko  = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_AND};
        vb  = '{16'h0001, 16'h0001, 16'h8000, 16'h0001, 16'h0001, 16'h0F0F};
        ovc = '{2'b10, 2'b01, 2'b11, 2'b10, 2'b01, 2'b00};  // {overflow, carry}
        errors = 0;
        num_checks = 0;
        clk_sys = 1'b0;
        arst_n = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h1;
        opValid = 1'b0;
        opKind = OP_LOAD;
        opOperand = 16'h0000;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        // reset values and masked readback
        chk(processorFlags, 8'h80, "flags port after reset");
        rdChk(A_FLG, 8'h80, "flags reset");
        rdChk(A_CTL, 8'h00, "control reset");
        wr(A_CTL, 8'h3C);
        rdChk(A_CTL, 8'h00, "reserved control bits");
        wr(A_PTR, 8'hFF);
        rdChk(A_PTR, 8'h03, "pointer upper bits");
        wr(A_BAD, 8'hFF);
        rdChk(A_BAD, 8'h00, "unmapped read");
        $display("test registers done");
        // every wrap code in both directions, several steps each
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr(A_CTL, 8'h00);
                wr(A_PTR, 8'h00);
                wr(A_CTL, {1'b0, d[0], 4'h0, m[1:0]});
                expPtr = 2'b00;
                for (int k = 0; k < 5; k++) begin
                    expPtr = stepOf(expPtr, m[1:0], d[0]);
                    doOp(ops[k % 4], 16'h0003);
                    chk({6'h00, activePointer}, {6'h00, expPtr}, "stepped pointer");
                end
                rdChk(A_PTR, {6'h00, expPtr}, "pointer readback");
            end
        end
        $display("test stepping done");
        // zeroing by software, bit drops back by itself
        wr(A_CTL, 8'h00);
        wr(A_PTR, 8'h02);
        wr(A_CTL, 8'h82);
        repeat (3) @(posedge clk_sys);
        rdChk(A_PTR, 8'h00, "pointer zeroed");
        rdChk(A_CTL, 8'h02, "zeroing bit self clears");
        // load instruction with zeroing bit set: clear only
        wr(A_CTL, 8'h00);
        wr(A_PTR, 8'h01);
        doOp(OP_LOAD, 16'h0082);
        doOp(OP_MVAPC, 16'h0000);
        chk({6'h00, activePointer}, 8'h00, "load instr clears");
        rdChk(A_CTL, 8'h02, "control after load instr");
        doOp(OP_ADD, 16'h0000);
        chk({6'h00, activePointer}, 8'h01, "stepping resumes");
        wr(A_CTL, 8'h00);
        $display("test zeroing done");
        // carry, overflow and zero across the signed corners
        for (int i = 0; i < 6; i++) begin
            doOp(OP_LOAD, va[i]);
            doOp(ko[i], vb[i]);
            chk({6'h00, processorFlags[2:1]}, {6'h00, ovc[i]}, "ovf and carry");
            chk({7'h00, processorFlags[7]}, {7'h00, (i > 0 && i < 3) || i == 5}, "zero");
            chk({7'h00, processorFlags[6]}, {7'h00, i == 0 || i == 4}, "sign");
        end
        doOp(OP_LOAD, 16'h1234);
        doOp(OP_CMP, 16'h1234);
        chk({7'h00, processorFlags[0]}, 8'h01, "equal on match");
        doOp(OP_CMP, 16'h1235);
        chk({7'h00, processorFlags[0]}, 8'h00, "equal on differ");
        chk(activeAcc[15:8], 8'h12, "active acc port");
        rdChk(6'h20, 8'h34, "active acc view");
        $display("test arithmetic flags done");
        // software access to the flags; zero and sign stay hardware owned
        doOp(OP_LOAD, 16'h0001);
        wr(A_FLG, 8'hFF);
        rdChk(A_FLG, 8'h1F, "flags after write ones");
        wr(A_FLG, 8'h00);
        rdChk(A_FLG, 8'h00, "flags after write zeros");
        doOp(OP_LOAD, 16'h0000);
        wr(A_FLG, 8'h04);
        rdChk(A_FLG, 8'h84, "overflow restore");
        avs_byteenable <= 4'h0;
        wr(A_FLG, 8'h1B);
        avs_byteenable <= 4'h1;
        rdChk(A_FLG, 8'h84, "disabled lane write");
        $display("test software flags done");
        // second reset in mid-run
        wr(A_PTR, 8'h03);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        chk(processorFlags, 8'h80, "flags after second reset");
        rdChk(A_PTR, 8'h00, "pointer after second reset");
        $display("test second reset done");
        close_out();
    end
endmodule
